// ### logic/haptic_pkg.sv
// Constants, register map and types for the haptic playback input control block
package haptic_pkg;
	// Register byte offsets
	localparam logic [7:0]  OFS_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_SEQ     = 8'h04;
	localparam logic [7:0]  OFS_TRIG    = 8'h08;
	localparam logic [7:0]  OFS_PINCFG  = 8'h0C;
	localparam logic [7:0]  OFS_LEVEL   = 8'h10;
	localparam logic [7:0]  OFS_PERIOD  = 8'h14;
	localparam logic [7:0]  OFS_STATUS  = 8'h18;
	// Control fields
	localparam int          CB_MODE     = 0;
	localparam int          CB_BOOST    = 3;
	localparam int          CB_CHAIN    = 4;
	localparam int          CB_WARM     = 5;
	localparam int          CB_FOLLOW   = 6;
	localparam int          CB_OVERRIDE = 7;
	localparam int          CB_AUTO     = 8;
	localparam int          CB_OVERDRV  = 9;
	localparam int          CB_QHALT    = 10;
	localparam int          CB_ERM      = 11;
	localparam logic [11:0] CTRL_RST    = 12'h000;
	// Sequence select: index [3:0], repeat count [7:4]; trigger bit
	localparam int          SB_REPEAT   = 4;
	localparam int          TB_START    = 0;
	// Pin config: per pin one byte, edge [1:0], alternation [2], index [7:4]
	localparam int          PIN_STRIDE  = 8;
	localparam int          PB_ALT      = 2;
	localparam int          PB_INDEX    = 4;
	localparam logic [23:0] PINCFG_RST  = 24'h000000;
	// Level register: min duty [7:0], nominal [15:8], peak [23:16]
	localparam int          LB_NOM      = 8;
	localparam int          LB_PEAK     = 16;
	localparam logic [23:0] LEVEL_RST   = 24'h000000;
	// Status fields; done flag is write-one-to-clear
	localparam int          ST_DONE     = 0;
	localparam int          ST_BUSY     = 1;
	localparam int          ST_WARM     = 2;
	localparam int          ST_STAGE    = 3;
	localparam int          ST_LOCK     = 4;
	localparam int          ST_FAULT    = 5;
	localparam int          ST_LEVEL    = 16;
	// Playback modes and edge selects
	localparam logic [2:0]  MODE_STREAM = 3'h2;
	localparam logic [2:0]  MODE_REG    = 3'h3;
	localparam logic [2:0]  MODE_PIN    = 3'h4;
	localparam logic [1:0]  EDGE_RISE   = 2'h0;
	localparam logic [1:0]  EDGE_FALL   = 2'h1;
	localparam logic [1:0]  EDGE_BOTH   = 2'h2;
	// Duty scale
	localparam logic [7:0]  DUTY_HALF   = 8'h80;
	localparam logic [7:0]  DUTY_FULL   = 8'hFF;
	// Resonance follow range and timing, periods in clock cycles
	localparam int          CLK_HZ      = 100_000_000;
	localparam int          FOLLOW_MIN_HZ = 50;
	localparam int          FOLLOW_MAX_HZ = 300;
	localparam logic [23:0] PER_MAX     = 24'(CLK_HZ / FOLLOW_MIN_HZ);
	localparam logic [23:0] PER_MIN     = 24'(CLK_HZ / FOLLOW_MAX_HZ);
	localparam logic [23:0] PERIOD_RST  = 24'h04C4B4;
	localparam logic [23:0] LOCK_TOL    = 24'h000100;
	localparam int          GAIN_SHIFT  = 4;
	localparam int          GAIN_SHIFT_FINE = 2;
	typedef enum logic [1:0] {PS_IDLE, PS_WARM, PS_PLAY} play_state_t;
endpackage : haptic_pkg

// ### logic/haptic_playback_ctrl.sv
// Playback input control: PWM streaming, sequence triggers, resonance follow
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module haptic_playback_ctrl
	import haptic_pkg::*;
#(
	parameter int SEQ_CYCLES = 1000,
	parameter int CNT_W      = 16
)(
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	// AHB-Lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// Trigger pins, pin 0 also streams
	input  wire logic [2:0]  trigger_pins_i,
	// Resonance measurement from sensing logic
	input  wire logic        res_valid_i,
	input  wire logic [23:0] res_period_i,
	// Drive and playback outputs
	output logic      [7:0]  drive_mag_o,
	output logic             drive_invert_o,
	output logic             phase_flip_o,
	output logic             stage_en_o,
	output logic      [23:0] drive_period_o,
	output logic             seq_active_o,
	output logic      [3:0]  seq_index_o,
	output logic             warm_standby_o,
	output logic             register_started_playback_o,
	output logic             pin_started_playback_o,
	output logic             interrupt_out_n_o,
	output logic             overdrive_active_o,
	output logic             quick_halt_active_o,
	output logic             gain_fine_o,
	output logic             follow_fault_o
);
	// Registers
	logic [11:0]      ctrl_r;
	logic [7:0]       seq_r;
	logic [23:0]      pincfg_r;
	logic [23:0]      level_cfg_r;
	logic [23:0]      period_r;
	logic             finished_flag_r;
	logic             trig_wr_r;
	logic             wr_pend_r;
	logic [7:0]       wr_addr_r;
	logic [2:0]       sync1_r, sync2_r, prev_r;
	logic [CNT_W-1:0] per_cnt_r, high_cnt_r;
	logic             per_ok_r;
	logic [7:0]       duty_r;
	logic signed [8:0] level_r;
	logic [23:0]      stage_cnt_r;
	logic             locked_r;
	play_state_t      state_r;
	logic [3:0]       loops_r;
	logic [31:0]      seq_cnt_r;
	logic [2:0]       parity_r;

	// Bus decode
	wire        addr_ok  = hsel_i && hready_i && htrans_i[1];
	wire        mapped   = haddr_i[31:8] == 24'h000000;
	wire        wr_ctrl  = wr_pend_r && wr_addr_r == OFS_CTRL;
	wire        wr_seq   = wr_pend_r && wr_addr_r == OFS_SEQ;
	wire        wr_trig  = wr_pend_r && wr_addr_r == OFS_TRIG;
	wire        wr_pin   = wr_pend_r && wr_addr_r == OFS_PINCFG;
	wire        wr_lvl   = wr_pend_r && wr_addr_r == OFS_LEVEL;
	wire        wr_per   = wr_pend_r && wr_addr_r == OFS_PERIOD;
	wire        wr_stat  = wr_pend_r && wr_addr_r == OFS_STATUS;
	wire [31:0] status_w = {{8{level_r[8]}}, level_r[7:0], 10'h000, follow_fault_o, locked_r,
	                        stage_en_o, state_r == PS_WARM, state_r == PS_PLAY, finished_flag_r};
	wire [31:0] rd_mux   = !mapped ? 32'h00000000 :
	                       haddr_i[7:0] == OFS_CTRL   ? {20'h00000, ctrl_r} :
	                       haddr_i[7:0] == OFS_SEQ    ? {24'h000000, seq_r} :
	                       haddr_i[7:0] == OFS_PINCFG ? {8'h00, pincfg_r} :
	                       haddr_i[7:0] == OFS_LEVEL  ? {8'h00, level_cfg_r} :
	                       haddr_i[7:0] == OFS_PERIOD ? {8'h00, period_r} :
	                       haddr_i[7:0] == OFS_STATUS ? status_w : 32'h00000000;

	// Control fields
	wire [2:0]  mode      = ctrl_r[CB_MODE +: 3];
	wire        boost     = ctrl_r[CB_BOOST];
	wire        follow_en = ctrl_r[CB_FOLLOW];
	wire        override  = ctrl_r[CB_OVERRIDE];
	wire [7:0]  min_duty_threshold = level_cfg_r[7:0];
	wire [7:0]  nom_lim   = level_cfg_r[LB_NOM +: 8];
	wire [7:0]  peak_lim  = level_cfg_r[LB_PEAK +: 8];
	wire        streaming = mode == MODE_STREAM;

	// Bus address phase capture and zero-wait answer
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			wr_pend_r   <= 1'b0;
			wr_addr_r   <= 8'h00;
			hrdata_o    <= 32'h00000000;
			hreadyout_o <= 1'b0;
			hresp_o     <= 1'b0;
		end
		else
		begin
			wr_pend_r   <= addr_ok && hwrite_i && mapped;
			wr_addr_r   <= haddr_i[7:0];
			hreadyout_o <= 1'b1;
			if (addr_ok && !hwrite_i)
				hrdata_o <= rd_mux;
		end
	end

	// Software register writes
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			ctrl_r      <= CTRL_RST;
			seq_r       <= 8'h00;
			pincfg_r    <= PINCFG_RST;
			level_cfg_r <= LEVEL_RST;
			trig_wr_r   <= 1'b0;
		end
		else
		begin
			if (wr_ctrl) ctrl_r <= hwdata_i[11:0];
			if (wr_seq) seq_r <= hwdata_i[7:0];
			if (wr_pin) pincfg_r <= hwdata_i[23:0];
			if (wr_lvl) level_cfg_r <= hwdata_i[23:0];
			trig_wr_r <= wr_trig && hwdata_i[TB_START];
		end
	end

	// Pin synchronisers, prev stage feeds edge detectors
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			sync1_r <= 3'b000;
			sync2_r <= 3'b000;
			prev_r  <= 3'b000;
		end
		else
		begin
			sync1_r <= trigger_pins_i;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	// Per-pin edge events
	wire [2:0] rise_w = sync2_r & ~prev_r;
	wire [2:0] fall_w = ~sync2_r & prev_r;
	logic [2:0] pin_ev;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_edge
			wire [1:0] sel = pincfg_r[gi*PIN_STRIDE +: 2];
			assign pin_ev[gi] = (sel == EDGE_RISE && rise_w[gi]) || (sel == EDGE_FALL && fall_w[gi]) ||
			                    (sel == EDGE_BOTH && (rise_w[gi] || fall_w[gi]));
		end
	endgenerate

	// Duty demodulator timed between rising edges of pin 0
	wire [23:0] duty_num = {8'h00, high_cnt_r} * 24'h0000FF;
	wire [23:0] duty_q   = duty_num / {8'h00, per_cnt_r};
	wire [7:0]  duty_w   = duty_q > 24'h0000FF ? DUTY_FULL : duty_q[7:0];
	wire        cnt_max  = &per_cnt_r;
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i || !streaming)
		begin
			per_cnt_r  <= '0;
			high_cnt_r <= '0;
			per_ok_r   <= 1'b0;
			duty_r     <= 8'h00;
		end
		else if (rise_w[0])
		begin
			if (per_ok_r && per_cnt_r != '0)
				duty_r <= duty_w;
			per_ok_r   <= 1'b1;
			per_cnt_r  <= CNT_W'(1);
			high_cnt_r <= CNT_W'(1);
		end
		else if (!cnt_max)
		begin
			per_cnt_r  <= per_cnt_r + CNT_W'(1);
			high_cnt_r <= high_cnt_r + CNT_W'(sync2_r[0]);
		end
	end

	// Level scaling
	wire [15:0]        prod_u = {8'h00, duty_r} * {8'h00, nom_lim};
	wire signed [8:0]  sduty  = $signed({1'b0, duty_r}) - $signed(9'h080);
	wire signed [17:0] prod_s = sduty * $signed({1'b0, peak_lim});
	wire signed [8:0]  lvl_nxt = duty_r < min_duty_threshold ? 9'sh000 :
	                             boost ? $signed({1'b0, prod_u[15:8]}) :
	                             $signed(prod_s[15:7]);
	wire [7:0] mag_nxt = level_r[8] ? 8'(-level_r) : level_r[7:0];

	// Drive level held until next demodulated duty; output rate set elsewhere
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i || !streaming)
			level_r <= 9'sh000;
		else
			level_r <= lvl_nxt;
	end

	// Drive outputs
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			drive_mag_o    <= 8'h00;
			drive_invert_o <= 1'b0;
			phase_flip_o   <= 1'b0;
		end
		else
		begin
			drive_mag_o    <= mag_nxt;
			drive_invert_o <= level_r[8] && ctrl_r[CB_ERM];
			phase_flip_o   <= level_r[8] && !ctrl_r[CB_ERM];
		end
	end

	// Output stage gating: off at zero, back after one half-period
	wire [23:0] half_per = {1'b0, period_r[23:1]};
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			stage_en_o  <= 1'b0;
			stage_cnt_r <= 24'h000000;
		end
		else if (!streaming || level_r == 9'sh000)
		begin
			stage_en_o  <= 1'b0;
			stage_cnt_r <= 24'h000000;
		end
		else if (!stage_en_o)
		begin
			stage_cnt_r <= stage_cnt_r + 24'h000001;
			stage_en_o  <= stage_cnt_r + 24'h000001 >= half_per;
		end
	end

	// Resonance follow loop
	wire [23:0] res_diff = res_period_i > period_r ? res_period_i - period_r : period_r - res_period_i;
	wire        in_range = res_period_i >= PER_MIN && res_period_i <= PER_MAX;
	wire        capture  = res_diff <= {2'b00, period_r[23:2]};
	wire        fine     = ctrl_r[CB_AUTO] && locked_r;
	wire [23:0] step     = fine ? res_diff >> GAIN_SHIFT_FINE : res_diff >> GAIN_SHIFT;
	wire [23:0] per_step = res_period_i > period_r ? period_r + step : period_r - step;
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			period_r       <= PERIOD_RST;
			locked_r       <= 1'b0;
			follow_fault_o <= 1'b0;
		end
		else
		begin
			// Clear comes first so a fault in the same cycle wins
			if (wr_stat && hwdata_i[ST_FAULT])
				follow_fault_o <= 1'b0;
			if (wr_per)
			begin
				period_r <= hwdata_i[23:0];
				locked_r <= 1'b0;
			end
			else if (follow_en && res_valid_i)
			begin
				if (override)
					period_r <= res_period_i;
				else if (!in_range)
					follow_fault_o <= 1'b1;
				else if (capture)
				begin
					period_r <= per_step;
					locked_r <= locked_r || res_diff <= LOCK_TOL;
				end
			end
		end
	end

	// Follow-dependent enables and registered drive period
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			overdrive_active_o  <= 1'b0;
			quick_halt_active_o <= 1'b0;
			gain_fine_o         <= 1'b0;
			drive_period_o      <= PERIOD_RST;
		end
		else
		begin
			overdrive_active_o  <= ctrl_r[CB_OVERDRV] && follow_en;
			quick_halt_active_o <= ctrl_r[CB_QHALT] && follow_en;
			gain_fine_o         <= fine && follow_en;
			drive_period_o      <= period_r;
		end
	end

	// Sequence start selection
	wire        pin_mode   = mode == MODE_PIN;
	wire        reg_mode   = mode == MODE_REG || pin_mode;
	wire        pin_start  = pin_mode && |pin_ev;
	wire [1:0]  first_pin  = pin_ev[0] ? 2'd0 : pin_ev[1] ? 2'd1 : 2'd2;
	wire [7:0]  pcfg       = pincfg_r[first_pin*PIN_STRIDE +: 8];
	wire        even_ev    = pcfg[PB_ALT] && parity_r[first_pin];
	wire [3:0]  pin_index  = pcfg[PB_INDEX +: 4] + {3'b000, even_ev};
	wire        can_start  = state_r != PS_PLAY;
	wire        start_reg  = can_start && reg_mode && trig_wr_r && !pin_start;
	wire        start_pin  = can_start && pin_start;
	wire        seq_end    = state_r == PS_PLAY && seq_cnt_r == 32'(SEQ_CYCLES - 1);
	wire        last_loop  = loops_r == 4'h0;
	wire        finish     = seq_end && last_loop;
	wire        stop_ev    = state_r == PS_PLAY && pin_started_playback_o && |pin_ev;
	wire        chain      = ctrl_r[CB_CHAIN];
	play_state_t rest_state;
	assign rest_state = ctrl_r[CB_WARM] ? PS_WARM : PS_IDLE;

	// Playback sequencer
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			state_r                     <= PS_IDLE;
			loops_r                     <= 4'h0;
			seq_cnt_r                   <= 32'h00000000;
			seq_index_o                 <= 4'h0;
			register_started_playback_o <= 1'b0;
			pin_started_playback_o      <= 1'b0;
		end
		else if (start_reg || start_pin)
		begin
			state_r                     <= PS_PLAY;
			loops_r                     <= seq_r[SB_REPEAT +: 4];
			seq_cnt_r                   <= 32'h00000000;
			seq_index_o                 <= start_pin ? pin_index : seq_r[3:0];
			register_started_playback_o <= start_reg;
			pin_started_playback_o      <= start_pin;
		end
		else if (stop_ev || (state_r == PS_PLAY && !reg_mode))
		begin
			state_r                <= rest_state;
			pin_started_playback_o <= 1'b0;
			register_started_playback_o <= 1'b0;
		end
		else if (finish && chain)
		begin
			loops_r   <= seq_r[SB_REPEAT +: 4];
			seq_cnt_r <= 32'h00000000;
		end
		else if (finish)
		begin
			state_r                     <= rest_state;
			register_started_playback_o <= 1'b0;
			pin_started_playback_o      <= 1'b0;
		end
		else if (seq_end)
		begin
			loops_r   <= loops_r - 4'h1;
			seq_cnt_r <= 32'h00000000;
		end
		else if (state_r == PS_PLAY)
			seq_cnt_r <= seq_cnt_r + 32'h00000001;
	end

	// Alternation parity per pin and finished flag, set beats clear
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			parity_r          <= 3'b000;
			finished_flag_r   <= 1'b0;
			interrupt_out_n_o <= 1'b1;
			seq_active_o      <= 1'b0;
			warm_standby_o    <= 1'b0;
		end
		else
		begin
			if (start_pin)
				parity_r[first_pin] <= !parity_r[first_pin];
			if (finish)
				finished_flag_r <= 1'b1;
			else if (wr_stat && hwdata_i[ST_DONE])
				finished_flag_r <= 1'b0;
			interrupt_out_n_o <= !(finish || finished_flag_r && !(wr_stat && hwdata_i[ST_DONE]));
			seq_active_o      <= state_r == PS_PLAY;
			warm_standby_o    <= state_r == PS_WARM;
		end
	end

	// Assertions
	sequence s_finish;
		finish;
	endsequence
	sequence s_flag_low;
		##1 finished_flag_r && !interrupt_out_n_o;
	endsequence
	a_finish_irq_low: assert property (@(posedge ref_clk_i) disable iff (rst_i) s_finish |-> s_flag_low)
		else $error("finish did not raise flag and interrupt");
	a_reg_mode_pins: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		mode == MODE_REG && can_start && |pin_ev && !trig_wr_r |=> state_r != PS_PLAY)
		else $error("pin edge started playback in register mode");
	a_threshold_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		streaming && duty_r < min_duty_threshold && $stable(ctrl_r) |=> level_r == 9'sh000)
		else $error("duty under threshold gave nonzero level");
	a_stage_zero_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		level_r == 9'sh000 |=> !stage_en_o)
		else $error("stage on at zero level");
	a_stage_wait_half: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$rose(stage_en_o) |-> stage_cnt_r >= half_per)
		else $error("stage re-enabled before half period");
	a_pin_event_stop: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		stop_ev && !start_reg |=> state_r != PS_PLAY && !pin_started_playback_o)
		else $error("second pin event did not stop playback");
	a_chain_restart: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		finish && chain && !stop_ev && reg_mode |=> state_r == PS_PLAY && seq_cnt_r == 32'h00000000)
		else $error("chained sequence did not restart");
	a_follow_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!follow_en ##1 !follow_en |-> !overdrive_active_o && !quick_halt_active_o)
		else $error("overdrive or quick halt without follow");
	a_rest_state: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		finish && !chain && !stop_ev && !start_reg && reg_mode |=> state_r == rest_state)
		else $error("wrong rest state after playback");
	a_fine_after_lock: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		gain_fine_o |-> $past(locked_r))
		else $error("fine gain before lock");
endmodule : haptic_playback_ctrl

// ### testbench/trigger_source.sv
// PWM and trigger pin source model facing the playback block
`timescale 1ns/10ps
module trigger_source (
	// Clock
	input  wire logic       clk_i,
	// Pins towards the block
	output logic      [2:0] pins_o
);
	logic [6:0] cnt_r;
	logic [6:0] high_r;
	logic       run_r;
	logic [2:0] lvl_r;
	initial
	begin
		cnt_r = 7'h00;
		high_r = 7'h00;
		run_r = 1'b0;
		lvl_r = 3'h0;
	end
	// Slow 128-cycle input frame keeps the stream rate low
	always @(posedge clk_i) cnt_r <= cnt_r + 7'h01;
	// Pin 0 carries the duty frame while streaming, else a static level
	assign pins_o = {lvl_r[2:1], run_r ? (cnt_r < high_r) : lvl_r[0]};
	task automatic pwm(input logic [6:0] h);
		high_r <= h;
		run_r <= 1'b1;
	endtask : pwm
	task automatic stop();
		run_r <= 1'b0;
	endtask : stop
	task automatic set_pin(input int i, input logic v);
		lvl_r[i] <= v;
	endtask : set_pin
endmodule : trigger_source

// ### testbench/haptic_playback_input_control_bench.sv
// Self-checking bench for the haptic playback input control block
`timescale 1ns/10ps
module haptic_playback_input_control_bench;
	import haptic_pkg::*;
	logic        ref_clk_i, rst_i, hsel_i, hwrite_i, res_valid_i, hreadyout_o, hresp_o;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, rd_data, dummy;
	logic [1:0]  htrans_i;
	logic [2:0]  hsize_i, trigger_pins_i;
	logic [23:0] res_period_i, drive_period_o;
	logic [7:0]  drive_mag_o;
	logic [3:0]  seq_index_o;
	logic        drive_invert_o, phase_flip_o, stage_en_o, seq_active_o, warm_standby_o;
	logic        reg_start, pin_start, interrupt_out_n_o;
	logic        od_act, qh_act, gain_fine, fault;
	logic [15:0] seed;
	logic [31:0] exp_q[$];
	string       name_q[$];
	int          fail_count, cmp_count, cycles;
	event        rd_ev;
	haptic_playback_ctrl #(.SEQ_CYCLES(10)) u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.trigger_pins_i(trigger_pins_i), .res_valid_i(res_valid_i), .res_period_i(res_period_i),
		.drive_mag_o(drive_mag_o), .drive_invert_o(drive_invert_o), .phase_flip_o(phase_flip_o),
		.stage_en_o(stage_en_o), .drive_period_o(drive_period_o), .seq_active_o(seq_active_o),
		.seq_index_o(seq_index_o), .warm_standby_o(warm_standby_o), .register_started_playback_o(reg_start),
		.pin_started_playback_o(pin_start), .interrupt_out_n_o(interrupt_out_n_o), .overdrive_active_o(od_act),
		.quick_halt_active_o(qh_act), .gain_fine_o(gain_fine), .follow_fault_o(fault));
	trigger_source u_src (.clk_i(ref_clk_i), .pins_o(trigger_pins_i));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic logic probe(input int w);
		return (w == 0) ? seq_active_o : interrupt_out_n_o;
	endfunction : probe
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, exp, seen);
		end
	endtask : check
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel_i <= 1'b1;
		haddr_i <= {24'h000000, a};
		htrans_i <= 2'h2;
		hwrite_i <= wr;
		do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
	endtask : ahb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d, dummy);
	endtask : wr
	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		name_q.push_back(n);
		ahb(1'b0, a, 32'h00000000, rd_data);
		-> rd_ev;
	endtask : rdchk
	task automatic wait_for(input int w, input logic v);
		for (int k = 0; k < 400 && probe(w) !== v; k++) @(posedge ref_clk_i);
		check("wait", {31'h0, probe(w)}, {31'h0, v});
	endtask : wait_for
	task automatic stream(input logic [6:0] h, input logic [7:0] m, input logic inv, flip, stg);
		u_src.pwm(h);
		repeat (400) @(posedge ref_clk_i);
		check("mag", {24'h0, drive_mag_o}, {24'h0, m});
		check("pol", {29'h0, drive_invert_o, phase_flip_o, stage_en_o}, {29'h0, inv, flip, stg});
	endtask : stream
	task final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	// Clock
	initial
	begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	// Read results compared against the oldest note
	initial forever
	begin
		@(rd_ev);
		check(name_q.pop_front(), rd_data, exp_q.pop_front());
	end
	// Hang guard
	always @(posedge ref_clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			final_report();
		end
	end
	// Main sequence
	initial
	begin
		{hsel_i, hwrite_i, res_valid_i, htrans_i, haddr_i, hwdata_i, res_period_i} = '0;
		hsize_i = 3'h2;
		seed = 16'h7413;
		rst_i = 1'b1;
		repeat (3) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		rdchk("ctrl", OFS_CTRL, {20'h0, CTRL_RST});
		rdchk("period", OFS_PERIOD, {8'h0, PERIOD_RST});
		rdchk("unmapped", 8'h40, 32'h00000000);
		check("hresp", {31'h0, hresp_o}, 32'h0);
		wr(OFS_PERIOD, 32'h000000C8);
		wr(OFS_PINCFG, 32'h00723550);
		wr(OFS_LEVEL, 32'h00808010);
		wr(OFS_CTRL, 32'h0000000A);
		stream(7'd96, 8'h5F, 1'b0, 1'b0, 1'b1);
		wr(OFS_CTRL, 32'h00000802);
		stream(7'd96, 8'h3F, 1'b0, 1'b0, 1'b1);
		stream(7'd32, 8'h41, 1'b1, 1'b0, 1'b1);
		stream(7'd8, 8'h00, 1'b0, 1'b0, 1'b0);
		wr(OFS_CTRL, 32'h00000002);
		stream(7'd32, 8'h41, 1'b0, 1'b1, 1'b1);
		check("period", {8'h0, drive_period_o}, 32'h000000C8);
		u_src.stop();
		wr(OFS_CTRL, 32'h00000003);
		u_src.set_pin(0, 1'b1);
		repeat (12) @(posedge ref_clk_i);
		check("pin in reg mode", {31'h0, seq_active_o}, 32'h0);
		u_src.set_pin(0, 1'b0);
		seed = lfsr(seed);
		wr(OFS_SEQ, {24'h0, seed[7:0]});
		wr(OFS_TRIG, 32'h00000001);
		wait_for(0, 1'b1);
		check("index", {28'h0, seq_index_o}, {28'h0, seed[3:0]});
		check("origin", {30'h0, reg_start, pin_start}, 32'h2);
		wait_for(1, 1'b0);
		rdchk("status", OFS_STATUS, 32'h00000001);
		wr(OFS_STATUS, 32'h00000001);
		wait_for(1, 1'b1);
		wr(OFS_CTRL, 32'h00000013);
		wr(OFS_SEQ, 32'h00000000);
		wr(OFS_TRIG, 32'h00000001);
		wait_for(1, 1'b0);
		repeat (3) @(posedge ref_clk_i);
		check("chain", {31'h0, seq_active_o}, 32'h1);
		wr(OFS_CTRL, 32'h00000004);
		wait_for(0, 1'b0);
		wr(OFS_STATUS, 32'h00000001);
		u_src.set_pin(0, 1'b1);
		wait_for(0, 1'b1);
		check("pin0", {27'h0, pin_start, seq_index_o}, 32'h15);
		wait_for(1, 1'b0);
		check("rest", {31'h0, warm_standby_o}, 32'h0);
		wr(OFS_STATUS, 32'h00000001);
		u_src.set_pin(0, 1'b0);
		u_src.set_pin(1, 1'b1);
		repeat (12) @(posedge ref_clk_i);
		check("rise on fall pin", {31'h0, seq_active_o}, 32'h0);
		for (int e = 0; e < 2; e++)
		begin
			u_src.set_pin(1, 1'b0);
			wait_for(0, 1'b1);
			check("alt", {28'h0, seq_index_o}, 32'h3 + e);
			wait_for(0, 1'b0);
			wr(OFS_STATUS, 32'h00000001);
			u_src.set_pin(1, 1'b1);
			repeat (4) @(posedge ref_clk_i);
		end
		u_src.set_pin(2, 1'b1);
		wait_for(0, 1'b1);
		check("pin2", {28'h0, seq_index_o}, 32'h7);
		u_src.set_pin(2, 1'b0);
		wait_for(0, 1'b0);
		check("stop flag", {31'h0, interrupt_out_n_o}, 32'h1);
		wr(OFS_CTRL, 32'h00000024);
		u_src.set_pin(0, 1'b1);
		wait_for(0, 1'b1);
		wait_for(0, 1'b0);
		repeat (2) @(posedge ref_clk_i);
		check("warm", {31'h0, warm_standby_o}, 32'h1);
		wr(OFS_CTRL, 32'h00000600);
		repeat (2) @(posedge ref_clk_i);
		check("od qh off", {30'h0, od_act, qh_act}, 32'h0);
		wr(OFS_CTRL, 32'h000006C0);
		res_period_i <= 24'h055555;
		res_valid_i <= 1'b1;
		@(posedge ref_clk_i);
		res_valid_i <= 1'b0;
		for (int k = 0; k < 20 && drive_period_o !== 24'h055555; k++) @(posedge ref_clk_i);
		check("follow", {8'h0, drive_period_o}, 32'h00055555);
		check("od qh on", {30'h0, od_act, qh_act}, 32'h3);
		wr(OFS_CTRL, 32'h00000740);
		res_period_i <= 24'h000100;
		res_valid_i <= 1'b1;
		@(posedge ref_clk_i);
		res_valid_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		check("fault", {30'h0, fault, gain_fine}, 32'h2);
		res_period_i <= 24'h055655;
		res_valid_i <= 1'b1;
		@(posedge ref_clk_i);
		res_valid_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		check("track", {8'h0, drive_period_o}, 32'h00055565);
		check("fine", {31'h0, gain_fine}, 32'h1);
		final_report();
	end
endmodule : haptic_playback_input_control_bench
